// ### dv/cdc_bus_model.sv
`timescale 1ns/1ps
// ****************************************
// Serial bus controller model.
// ****************************************
module cdc_bus_model (
  // Reference clock.
  input wire logic clk,
  // Bus pins.
  output logic bclk,
  output logic fs_n,
  output logic csi,
  output logic psi,
  output logic [1:0] sel,
  input wire logic pso,
  input wire logic pso_oe
);
  int ph = 0;
  bit stop_hi = 1'b0;

  // Pins start idle.
  initial begin
    bclk = 1'b0;
    fs_n = 1'b1;
    csi = 1'b0;
    psi = 1'b0;
    sel = 2'b01;
  end

  // Free bit clock near 2.048 MHz; the bench may freeze it high.
  always @(negedge clk) begin
    ph <= (ph == 60) ? 0 : ph + 1;
    if (stop_hi)
      bclk <= 1'b1;
    else if (ph == 60)
      bclk <= ~bclk;
  end

  // One slot of eight bits, set after each falling edge. Idle control
  // input stays low, because a high level would command powerdown.
  task automatic xfer(input logic [7:0] cw, input logic [7:0] pw,
    input logic [1:0] s, output logic [7:0] got, output logic [1:0] oe);
    oe = 2'b01;
    for (int i = 8; i >= 0; i--) begin
      @(negedge bclk);
      if (i < 8) begin
        got[i] = pso;
        oe = {oe[1] | pso_oe, oe[0] & pso_oe};
      end
      @(negedge clk);
      fs_n = (i == 0);
      sel = s;
      csi = (i > 0) ? cw[i-1] : 1'b0;
      psi = (i > 0) ? pw[i-1] : ~psi;
    end
  endtask

  // Control input held at a level with the lowest select.
  task automatic hold_csi(input logic v);
    @(negedge clk);
    sel = 2'b00;
    csi = v;
    repeat (10) @(negedge bclk);
  endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("BAD %s expected %h seen %h", nm, e, g); \
  end \
end
// ****************************************
// Top-level bench.
// ****************************************
module testbench;
  localparam int LOC = 100;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] enc_word = 8'h00;
  logic dec_ready = 1'b0;
  wire bclk, fs_n, csi, psi, pso, pso_oe, pd, dec_valid, ovr;
  wire [1:0] sel;
  wire [5:0] aux_o, aux_oe;
  wire [7:0] dec_word;
  cdc_pkg::cdc_ctrl_t ctrl;
  int seed = 37;
  int n_mismatch = 0;
  int tests_run = 0;
  int rises = 0;
  bit hold = 1'b1;
  bit ign = 1'b0;
  logic [7:0] ra, rb, last_in;
  logic [7:0] q[$];

  // Clock of 4 ns period.
  always #2 ref_clk = ~ref_clk;

  // Loss-of-clock time is shortened, yet above one bit-clock half period.
  cdc_ctrl #(.LOC_CYCLES(LOC), .REDUCED_PINS(1'b0)) cdc_ctrl_inst (
    .REF_CLK(ref_clk), .RSTN(rstn), .BIT_CLOCK_IN(bclk),
    .FRAME_SYNC_N(fs_n), .CONTROL_SERIAL_IN(csi), .PCM_SERIAL_IN(psi),
    .CONTROL_ADDRESS_SELECT(sel), .PCM_SERIAL_OUT_O(pso),
    .PCM_SERIAL_OUT_OE(pso_oe), .AUX_DRIVE_OUTPUTS_O(aux_o),
    .AUX_DRIVE_OUTPUTS_OE(aux_oe), .ENC_WORD(enc_word),
    .DEC_WORD(dec_word), .DEC_VALID(dec_valid), .DEC_READY(dec_ready),
    .CTRL(ctrl), .POWERDOWN(pd), .RX_OVERRUN(ovr));

  cdc_bus_model cdc_bus_model_inst (
    .clk(ref_clk), .bclk(bclk), .fs_n(fs_n), .csi(csi), .psi(psi),
    .sel(sel), .pso(pso), .pso_oe(pso_oe));

  // Rises since reset release tell when loads are allowed.
  always @(posedge bclk) rises++;

  // Random decoder stalls; never take more than the model expects.
  always @(negedge ref_clk)
    dec_ready <= !hold && (ign || q.size() > 0) && $random(seed) % 2 != 0;

  // Each decoder transfer outside a mode-change flush is compared with the model queue.
  always @(posedge ref_clk) begin
    logic [7:0] e;
    if (dec_valid === 1'b1 && dec_ready && !ign) begin
      e = q.pop_front();
      `CHK("dec_word", e, dec_word)
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic give_up();
    n_mismatch++;
    $display("BAD wait expected done seen timeout");
    complete_run();
  endtask

  task automatic chk_state();
    `CHK("ctrl", {ra[7:6], rb[7:6], ra[5:0]}, ctrl)
    `CHK("pd", ra[7:6] == 2'b11, pd)
    `CHK("aux_o", {3'b000, rb[2:0]}, aux_o)
    `CHK("aux_oe", {rb[5:3], 3'b111}, aux_oe)
  endtask

  task automatic drain();
    for (int k = 0; k < 4000 && q.size() > 0; k++)
      @(negedge ref_clk);
    if (q.size() != 0)
      give_up();
  endtask

  task automatic wait_live();
    for (int k = 0; k < 5000 && rises < 27; k++)
      @(negedge ref_clk);
    if (rises < 27)
      give_up();
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    hold = 1'b1;
    q.delete();
    ra = 8'hc0;
    rb = 8'h00;
    repeat (16) @(negedge ref_clk);
    chk_state();
    `CHK("pcm_oe_rst", 1'b0, pso_oe)
    rises = 0;
    rstn = 1'b1;
    hold = 1'b0;
  endtask

  // One slot through the model, then the expected register effects.
  // A mode change drains first and discards its own decoder word,
  // since that word straddles two modes.
  task automatic word(input logic [7:0] cw, input logic [7:0] pw,
    input logic [1:0] s);
    logic [7:0] got;
    logic [1:0] oe;
    logic [7:0] ex;
    bit live;
    bit on;
    bit chg;
    bit on_nx;
    live = rises > 25;
    on = live && s != 2'b10 && ra[7:6] != 2'b11;
    on_nx = live && s != 2'b10 && cw[7:6] != 2'b11;
    chg = live && s != 2'b10 && cw[7:6] != ra[7:6];
    if (chg)
      drain();
    @(negedge ref_clk);
    enc_word = 8'($random(seed));
    ex = (ra[7:6] == 2'b01) ? last_in : enc_word;
    if (on && !chg && (!hold || q.size() < 32))
      q.push_back(ra[7:6] == 2'b01 ? 8'h00 : pw);
    cdc_bus_model_inst.xfer(cw, pw, s, got, oe);
    if (on) `CHK("pcm_out", ex, got)
    // The enable follows powerdown at once, so the last bit, sampled after
    // this word has loaded, already shows the new powerdown state.
    `CHK("pcm_oe", {on | on_nx, on & on_nx}, oe)
    if (live && s == 2'b10)
      rb = cw;
    else if (live) begin
      if (s == 2'b00)
        rb = 8'h00;
      ra = cw;
      last_in = pw;
    end
    chk_state();
    if (chg) begin
      ign = 1'b1;
      for (int k = 0; k < 400 && dec_valid !== 1'b0; k++)
        @(negedge ref_clk);
      `CHK("flush", 1'b0, dec_valid)
      ign = 1'b0;
    end
  endtask

  // Main sequence.
  initial begin
    logic [7:0] v;
    do_reset();
    word(8'h15, 8'h3c, 2'b00);
    wait_live();
    for (int t = 0; t < 4; t++) begin
      v = 8'($random(seed));
      word({t[1:0], v[5:0]}, v, 2'b10);
    end
    word({2'b00, 6'($random(seed))}, 8'h00, 2'b01);
    repeat (2) word(ra, 8'($random(seed)), 2'b01);
    word({2'b01, ra[5:0]}, 8'h81, 2'b01);
    word(ra, 8'h5a, 2'b01);
    word(8'h2d, 8'hff, 2'b10);
    word(ra, 8'hc3, 2'b01);
    word({2'b10, ra[5:0]}, 8'h42, 2'b01);
    repeat (2) word(ra, 8'($random(seed)), 2'b01);
    word({2'b11, ra[5:0]}, 8'h00, 2'b01);
    word(8'h15, 8'h99, 2'b10);
    word(8'hc7, 8'h66, 2'b01);
    word({2'b00, ra[5:0]}, 8'h00, 2'b00);
    hold = 1'b1;
    repeat (32) word(ra, 8'($random(seed)), 2'b00);
    `CHK("ovr0", 1'b0, ovr)
    repeat (2) word(ra, 8'($random(seed)), 2'b00);
    `CHK("ovr1", 1'b1, ovr)
    `CHK("dec_valid", 1'b1, dec_valid)
    hold = 1'b0;
    drain();
    cdc_bus_model_inst.hold_csi(1'b1);
    `CHK("pd_csi", 1'b1, pd)
    cdc_bus_model_inst.hold_csi(1'b0);
    do_reset();
    wait_live();
    word(8'h3f, 8'h00, 2'b10);
    word(8'h2a, 8'h00, 2'b01);
    cdc_bus_model_inst.stop_hi = 1'b1;
    repeat (LOC + 200) @(negedge ref_clk);
    ra = 8'hc0;
    rb = 8'h00;
    chk_state();
    complete_run();
  end

  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge ref_clk);
    give_up();
  end
endmodule

// ### hdl/cdc_ctrl.sv
// Function
// - Register A bits 7:6 choose loopback.
// - Digital loopback routes input register to output.
// - Digital loopback forces decoder word to zero.
// - Digital loopback discards encoder, echoes PCM input.
// - Analog loopback decodes and re-encodes normally.
// - Register B bits 0-5 drive aux outputs.
// - Aux 0-2 are push-pull outputs.
// - Aux 3-5 are open-drain outputs.
// - Reduced build keeps only aux 0-3.
// - Register B bits 7:6 select test mode.
// - Power-up holds powerdown 25 bit clocks.
// - Power-up clears register B.
// - Power-up sets register A to powerdown.
// - Stuck-high bit clock re-enters reset powerdown.
// - Register A 11 forces powerdown.
// - Powerdown floats PCM output, stops logic.
// - Powerdown keeps aux, register B updates.
// - Held-high control input at low select powers down.
// - Control words arrive MSB first.
// - One control word per frame slot.
// - High select loads B, inhibits PCM.
// - Low select A load clears register B.
`timescale 1ns/1ps
`include "cdc_regs.svh"

// ****************************************
// Receive word buffer.
// ****************************************
module cdc_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;

  // Full when the pointers differ only in the wrap bit.
  assign in_ready = (wr_ptr_ff ^ rd_ptr_ff) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_ff != rd_ptr_ff;
  assign out_data = mem[rd_ptr_ff[AW-1:0]];

  // Storage has no reset; only the pointers define content.
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // Pointer advance on each accepted transfer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule

// ****************************************
// Control, loopback and powerdown logic.
// ****************************************
module cdc_ctrl #(
  parameter int LOC_CYCLES = `CDC_LOC_TIME_NS / `CDC_CLK_PERIOD_NS,
  parameter bit REDUCED_PINS = 1'b0
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Serial bus pins.
  input wire logic BIT_CLOCK_IN,
  input wire logic FRAME_SYNC_N,
  input wire logic CONTROL_SERIAL_IN,
  input wire logic PCM_SERIAL_IN,
  input wire logic [1:0] CONTROL_ADDRESS_SELECT,
  output logic PCM_SERIAL_OUT_O,
  output logic PCM_SERIAL_OUT_OE,
  // Auxiliary drive pins.
  output logic [5:0] AUX_DRIVE_OUTPUTS_O,
  output logic [5:0] AUX_DRIVE_OUTPUTS_OE,
  // Codec core side.
  input wire logic [7:0] ENC_WORD,
  output logic [7:0] DEC_WORD,
  output logic DEC_VALID,
  input wire logic DEC_READY,
  output cdc_pkg::cdc_ctrl_t CTRL,
  output logic POWERDOWN,
  output logic RX_OVERRUN
);
  logic [5:0] pin_raw;
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  logic [5:0] s3_ff;
  logic [5:0] pin_ff;
  logic [5:0] nxt_pin;
  logic bclk_d_ff;
  logic bclk_rise;
  logic fs_n;
  logic csi;
  logic psi;
  logic [1:0] ca;
  cdc_pkg::cdc_state_t state_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] csi_sr_ff;
  logic [6:0] psi_sr_ff;
  logic [7:0] rega_ff;
  logic [7:0] regb_ff;
  logic [7:0] in_reg_ff;
  logic [7:0] out_sr_ff;
  logic pcm_oe_ff;
  logic rst_pd_ff;
  logic [4:0] pu_cnt_ff;
  logic [15:0] loc_cnt_ff;
  logic [3:0] csi_hi_cnt_ff;
  logic pend_ff;
  logic ovr_ff;
  logic word_done;
  logic slot_start;
  logic reg_pd;
  logic csi_pd;
  logic pd_any;
  logic dig_loop;
  logic ca_high;
  logic [7:0] tx_word;
  logic fifo_ready;
  logic [7:0] fifo_data;

  // ****************************************
  // Pin synchronisers.
  // ****************************************
  assign pin_raw = {CONTROL_ADDRESS_SELECT, PCM_SERIAL_IN,
                    CONTROL_SERIAL_IN, FRAME_SYNC_N, BIT_CLOCK_IN};

  // A level is taken only when stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      assign nxt_pin[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] :
                           pin_ff[gi];
    end
  endgenerate

  // Three stages in one process. Reset loads the resting levels, so a bit
  // clock that sits high at release is not mistaken for a rising edge.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_ff <= `CDC_PIN_IDLE;
      s2_ff <= `CDC_PIN_IDLE;
      s3_ff <= `CDC_PIN_IDLE;
      pin_ff <= `CDC_PIN_IDLE;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= nxt_pin;
    end
  end

  assign fs_n = pin_ff[1];
  assign csi = pin_ff[2];
  assign psi = pin_ff[3];
  assign ca = pin_ff[5:4];
  assign ca_high = ca == `CDC_CA_HIGH;
  assign bclk_rise = pin_ff[0] && !bclk_d_ff;
  assign word_done = bclk_rise && !fs_n && bit_cnt_ff == `CDC_LAST_BIT;
  assign slot_start = bclk_rise && !fs_n && bit_cnt_ff == 3'h0;
  assign dig_loop = rega_ff[`CDC_A_LOOP_HI:`CDC_A_LOOP_LO] ==
                    cdc_pkg::CDC_LOOP_DIG;
  assign reg_pd = rega_ff[`CDC_A_LOOP_HI:`CDC_A_LOOP_LO] ==
                  cdc_pkg::CDC_LOOP_PD;
  assign csi_pd = csi_hi_cnt_ff == `CDC_CSI_PD_BITS;
  assign pd_any = rst_pd_ff || reg_pd || csi_pd;

  // ****************************************
  // Reset powerdown and loss of clock.
  // ****************************************
  // The stuck-clock timer runs on the reference clock, since the bit
  // clock cannot time its own absence.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      bclk_d_ff <= 1'b1; // Matches the synchroniser's resting level.
      loc_cnt_ff <= '0;
      rst_pd_ff <= 1'b1;
      pu_cnt_ff <= '0;
    end else begin
      bclk_d_ff <= pin_ff[0];
      if (!pin_ff[0]) begin
        loc_cnt_ff <= '0;
      end else if (loc_cnt_ff != 16'(LOC_CYCLES)) begin
        loc_cnt_ff <= loc_cnt_ff + 1'b1;
      end
      if (loc_cnt_ff == 16'(LOC_CYCLES - 1)) begin
        rst_pd_ff <= 1'b1;
        pu_cnt_ff <= '0;
      end else if (rst_pd_ff && bclk_rise) begin
        if (pu_cnt_ff == `CDC_PU_BITS - 5'h1) begin
          rst_pd_ff <= 1'b0;
        end
        pu_cnt_ff <= pu_cnt_ff + 1'b1;
      end
    end
  end

  // Held-high control input with low select, counted in bit clocks.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      csi_hi_cnt_ff <= '0;
    end else if (!csi || ca != `CDC_CA_LOW) begin
      csi_hi_cnt_ff <= '0;
    end else if (bclk_rise && !csi_pd) begin
      csi_hi_cnt_ff <= csi_hi_cnt_ff + 1'b1;
    end
  end

  // ****************************************
  // Slot framing and serial shift in.
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= cdc_pkg::CDC_ST_IDLE;
      bit_cnt_ff <= '0;
      csi_sr_ff <= '0;
      psi_sr_ff <= '0;
    end else if (bclk_rise && !rst_pd_ff) begin
      case (state_ff)
        cdc_pkg::CDC_ST_IDLE: begin
          bit_cnt_ff <= '0;
          if (!fs_n) begin
            state_ff <= cdc_pkg::CDC_ST_SLOT;
            bit_cnt_ff <= 3'h1;
            csi_sr_ff <= {6'h00, csi};
            psi_sr_ff <= {6'h00, psi};
          end
        end
        cdc_pkg::CDC_ST_SLOT: begin
          if (fs_n) begin
            state_ff <= cdc_pkg::CDC_ST_IDLE;
            bit_cnt_ff <= '0;
          end else begin
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
            csi_sr_ff <= {csi_sr_ff[5:0], csi};
            psi_sr_ff <= {psi_sr_ff[5:0], psi};
          end
        end
        default: begin
          state_ff <= cdc_pkg::CDC_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Control registers.
  // ****************************************
  // Loads are refused outright during reset powerdown.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rega_ff <= `CDC_A_RST;
      regb_ff <= `CDC_B_RST;
    end else if (rst_pd_ff) begin
      rega_ff <= `CDC_A_RST;
      regb_ff <= `CDC_B_RST;
    end else if (word_done && ca_high) begin
      regb_ff <= {csi_sr_ff, csi};
    end else if (word_done) begin
      rega_ff <= {csi_sr_ff, csi};
      if (ca == `CDC_CA_LOW) begin
        regb_ff <= `CDC_B_RST;
      end
    end
  end

  // ****************************************
  // PCM receive, loopback and transmit.
  // ****************************************
  // The input register latches outside high select and powerdown so digital loopback can echo it;
  // the buffer push stalls while full and a newer word overwrites it.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      in_reg_ff <= '0;
      pend_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      if (word_done && !ca_high && !pd_any) begin
        in_reg_ff <= {psi_sr_ff, psi};
        pend_ff <= 1'b1;
        ovr_ff <= pend_ff && !fifo_ready;
      end else if (pend_ff && fifo_ready) begin
        pend_ff <= 1'b0;
      end
    end
  end

  assign tx_word = dig_loop ? in_reg_ff : ENC_WORD;

  // Output shifter drives one bit per bit clock within the slot.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      out_sr_ff <= '0;
      pcm_oe_ff <= 1'b0;
    end else if (bclk_rise) begin
      if (slot_start) begin
        out_sr_ff <= tx_word;
      end else begin
        out_sr_ff <= {out_sr_ff[6:0], 1'b0};
      end
      pcm_oe_ff <= !fs_n && !ca_high && !rst_pd_ff;
    end
  end

  assign PCM_SERIAL_OUT_O = out_sr_ff[7];
  assign PCM_SERIAL_OUT_OE = pcm_oe_ff && !pd_any;

  cdc_fifo #(
    .W(8),
    .D(32)
  ) u_fifo (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .in_valid(pend_ff && !pd_any),
    .in_ready(fifo_ready),
    .in_data(in_reg_ff),
    .out_valid(DEC_VALID),
    .out_ready(DEC_READY),
    .out_data(fifo_data)
  );

  assign DEC_WORD = dig_loop ? 8'h00 : fifo_data;
  assign RX_OVERRUN = ovr_ff;
  assign POWERDOWN = pd_any;
  assign CTRL.loop =
    cdc_pkg::cdc_loop_t'(rega_ff[`CDC_A_LOOP_HI:`CDC_A_LOOP_LO]);
  assign CTRL.test =
    cdc_pkg::cdc_test_t'(regb_ff[`CDC_B_TEST_HI:`CDC_B_TEST_LO]);
  assign CTRL.rx_gain = rega_ff[`CDC_A_RXG_HI:`CDC_A_RXG_LO];
  assign CTRL.tx_gain = rega_ff[`CDC_A_TXG_HI:`CDC_A_TXG_LO];

  // ****************************************
  // Auxiliary drive outputs.
  // ****************************************
  // Low three drive both levels; upper three only pull low when active.
  generate
    for (gi = 0; gi < 6; gi++) begin : g_aux
      if (gi <= `CDC_AUX_PP_LAST) begin : g_pp
        assign AUX_DRIVE_OUTPUTS_O[gi] = regb_ff[gi];
        assign AUX_DRIVE_OUTPUTS_OE[gi] = 1'b1;
      end else begin : g_od
        assign AUX_DRIVE_OUTPUTS_O[gi] = 1'b0;
        assign AUX_DRIVE_OUTPUTS_OE[gi] = regb_ff[gi] &&
          (!REDUCED_PINS || gi <= `CDC_AUX_REDUCED_LAST);
      end
    end
  endgenerate

  // ****************************************
  // Checks.
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_load_b;
    word_done && ca_high && !rst_pd_ff;
  endsequence
  sequence s_load_a_low;
    word_done && !ca_high && ca == `CDC_CA_LOW && !rst_pd_ff;
  endsequence

  property p_dig_zero;
    dig_loop |-> DEC_WORD == 8'h00;
  endproperty
  a_dig_zero: assert property (p_dig_zero)
    else $error("Decoder word not zero in digital loopback.");
  property p_dig_echo;
    slot_start && dig_loop |=> out_sr_ff == $past(in_reg_ff);
  endproperty
  a_dig_echo: assert property (p_dig_echo)
    else $error("Digital loopback did not echo input word.");
  property p_load_b;
    s_load_b |=> regb_ff == $past({csi_sr_ff, csi}) &&
      $stable(rega_ff);
  endproperty
  a_load_b: assert property (p_load_b)
    else $error("High select word did not load register B alone.");
  property p_clear_b;
    s_load_a_low |=> regb_ff == `CDC_B_RST;
  endproperty
  a_clear_b: assert property (p_clear_b)
    else $error("Low select load did not clear register B.");
  property p_rst_vals;
    rst_pd_ff ##1 rst_pd_ff |-> rega_ff == `CDC_A_RST &&
      regb_ff == `CDC_B_RST;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("Registers not at power-up values in reset powerdown.");
  property p_loc;
    pin_ff[0] && loc_cnt_ff == 16'(LOC_CYCLES - 1) |=> rst_pd_ff;
  endproperty
  a_loc: assert property (p_loc)
    else $error("Stuck bit clock did not enter reset powerdown.");
  property p_pd_hiz;
    reg_pd || csi_pd |-> !PCM_SERIAL_OUT_OE && POWERDOWN;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz)
    else $error("PCM output driven during powerdown.");
  property p_pu_exit;
    rst_pd_ff && bclk_rise && pu_cnt_ff == `CDC_PU_BITS - 5'h1 &&
      loc_cnt_ff != 16'(LOC_CYCLES - 1) |=> !rst_pd_ff;
  endproperty
  a_pu_exit: assert property (p_pu_exit)
    else $error("Reset powerdown did not end after 25 bit clocks.");
  property p_aux_keep;
    reg_pd && !word_done && !rst_pd_ff |=>
      $stable(AUX_DRIVE_OUTPUTS_OE);
  endproperty
  a_aux_keep: assert property (p_aux_keep)
    else $error("Aux outputs changed in powerdown without a load.");
endmodule

// ### hdl/cdc_pkg.sv
package cdc_pkg;
  typedef enum logic [1:0] {
    CDC_LOOP_NONE = 2'h0,
    CDC_LOOP_DIG = 2'h1,
    CDC_LOOP_ANA = 2'h2,
    CDC_LOOP_PD = 2'h3
  } cdc_loop_t;
  typedef enum logic [1:0] {
    CDC_TEST_NONE = 2'h0,
    CDC_TEST_TXF = 2'h1,
    CDC_TEST_RXF = 2'h2,
    CDC_TEST_CODEC = 2'h3
  } cdc_test_t;
  typedef enum logic [1:0] {
    CDC_ST_IDLE = 2'b01,
    CDC_ST_SLOT = 2'b10
  } cdc_state_t;
  typedef struct packed {
    cdc_loop_t loop;
    cdc_test_t test;
    logic [2:0] rx_gain;
    logic [2:0] tx_gain;
  } cdc_ctrl_t;
endpackage

// ### hdl/cdc_regs.svh
`ifndef CDC_REGS_SVH
`define CDC_REGS_SVH
// Control word A field positions and its power-up value.
`define CDC_A_LOOP_HI 7
`define CDC_A_LOOP_LO 6
`define CDC_A_RXG_HI 5
`define CDC_A_RXG_LO 3
`define CDC_A_TXG_HI 2
`define CDC_A_TXG_LO 0
`define CDC_A_RST 8'hc0
// Control word B field positions and its power-up value.
`define CDC_B_TEST_HI 7
`define CDC_B_TEST_LO 6
`define CDC_B_RST 8'h00
`define CDC_AUX_PP_LAST 2
`define CDC_AUX_REDUCED_LAST 3
// Address select levels as encoded on the two select wires.
`define CDC_CA_LOW 2'b00
`define CDC_CA_HIGH 2'b10
// Pin levels held in the synchronisers during reset. Bit clock and frame
// sync rest high, so no edge is seen when reset lets go.
`define CDC_PIN_IDLE 6'h03
// Serial word timing in bit-clock cycles.
`define CDC_LAST_BIT 3'h7
`define CDC_PU_BITS 5'h19
`define CDC_CSI_PD_BITS 4'h8
// Reference clock and loss-of-clock timing.
`define CDC_CLK_PERIOD_NS 4
`define CDC_LOC_TIME_NS 20000
`endif
